// File: bench/bsto_stage_tb_top.sv
// Self-checking bench for the back-face stencil test and fail-update stage.
`timescale 1ns/1ps
`default_nettype none
module bsto_stage_tb_top
    import bsto_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n, ds_en, f_ccw, cull_en, pv, p_ccw;
    logic [31:0] sw;
    logic [2:0]  f_cmp, f_fail, o_cmp, o_fop;
    logic [7:0]  s_ref, s_cur, o_st;
    logic        o_vld, o_back, o_cull, o_pass;
    int          fails = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    // Twenty nanosecond half period gives the 25 MHz pipeline clock.
    always #20 clk = ~clk;
    bsto_stage uut (.clk(clk), .rst_n(rst_n), .state_word(sw),
        .double_sided_en(ds_en), .front_cmp_code(f_cmp),
        .front_fail_code(f_fail), .front_ccw(f_ccw), .cull_back_en(cull_en),
        .pix_valid(pv), .prim_ccw(p_ccw), .stencil_ref(s_ref),
        .stencil_cur(s_cur), .res_valid_ff(o_vld), .res_back_ff(o_back),
        .res_culled_ff(o_cull), .res_pass_ff(o_pass), .res_cmp_ff(o_cmp),
        .res_fail_op_ff(o_fop), .res_stencil_ff(o_st));
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // A hung run is cut short and counted as a mismatch.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    // Compare is reference against current value, in that operand order.
    function automatic logic f_pass(input logic [2:0] c,
                                    input logic [7:0] r, s);
        case (c)
            3'h0: return 1'b1;
            3'h1: return 1'b0;
            3'h2: return r < s;
            3'h3: return r == s;
            3'h4: return r <= s;
            3'h5: return r > s;
            3'h6: return r != s;
            default: return r >= s;
        endcase
    endfunction
    function automatic logic [7:0] f_upd(input logic [2:0] o,
                                         input logic [7:0] r, s);
        case (o)
            3'h0: return s;
            3'h1: return 8'h00;
            3'h2: return r;
            3'h3: return (s == 8'hFF) ? s : s + 8'h01;
            3'h4: return (s == 8'h00) ? s : s - 8'h01;
            3'h5: return s + 8'h01;
            3'h6: return s - 8'h01;
            default: return ~s;
        endcase
    endfunction
    // One pixel, driven at a falling edge and judged at the next falling edge.
    task automatic px(input logic [2:0] bc, bf, input logic ds, pc, cu, v,
                      input logic [7:0] r, s);
        logic       bk;
        logic [2:0] ec, ef;
        logic       ep;
        bk = pc ^ f_ccw;
        ec = (bk & ds) ? bc : f_cmp;
        ef = (bk & ds) ? bf : f_fail;
        ep = f_pass(ec, r, s);
        sw = {17'h1FFFF, bc, bf, 9'h1FF};
        {ds_en, p_ccw, cull_en, pv, s_ref, s_cur} = {ds, pc, cu, v, r, s};
        @(negedge clk);
        chk("valid", 8'(v), 8'(o_vld));
        chk("back", 8'(bk), 8'(o_back));
        chk("culled", 8'(v & bk & cu), 8'(o_cull));
        chk("cmp_code", 8'(ec), 8'(o_cmp));
        chk("fail_op", 8'(ef), 8'(o_fop));
        chk("pass", 8'(ep), 8'(o_pass));
        chk("stencil", ep ? s : f_upd(ef, r, s), o_st);
    endtask
    // Every compare code against below, equal and above operands.
    task automatic t_cmp();
        {f_ccw, f_cmp, f_fail} = {1'b0, 3'h1, 3'h0};
        for (int i = 0; i < 8; i++) begin
            for (int k = 0; k < 3; k++) begin
                px(3'(i), 3'h1, 1'b1, 1'b1, 1'b0, 1'b1,
                   8'(16 + 16 * k), 8'h20);
            end
        end
    endtask
    // Every update code on a failing test, at both clamp edges.
    task automatic t_ops();
        logic [7:0] cv [3] = '{8'h00, 8'hFF, 8'h5A};
        {f_ccw, f_cmp, f_fail} = {1'b1, 3'h0, 3'h0};
        for (int i = 0; i < 8; i++) begin
            for (int k = 0; k < 3; k++) begin
                px(3'h1, 3'(i), 1'b1, 1'b0, 1'b0, 1'b1,
                   8'hC3, cv[k]);
            end
        end
    endtask
    // Double-sided off: back faces must follow the front codes only.
    task automatic t_single();
        f_ccw = 1'b0;
        for (int i = 0; i < 8; i++) begin
            {f_cmp, f_fail} = {3'(i), 3'(7 - i)};
            px(3'(7 - i), 3'(i), 1'b0, 1'b1, 1'b0, 1'b1,
               8'h40, 8'h40);
        end
    endtask
    // Culling and facing over every mix of enables, both front windings.
    task automatic t_cull();
        {f_cmp, f_fail} = {3'h1, 3'h7};
        for (int i = 0; i < 32; i++) begin
            f_ccw = i[4];
            px(3'h0, 3'h3, i[3], i[2], i[1], i[0],
               8'h01, 8'h02);
        end
    endtask
    // Inputs get values at time zero; reset is held for two cycles.
    initial begin
        {rst_n, ds_en, f_ccw, cull_en, pv, p_ccw} = 6'h00;
        {sw, f_cmp, f_fail, s_ref, s_cur} = '0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk("reset_out", 8'h00, {o_vld, o_back, o_cull, o_pass, o_st[3:0]});
        chk("reset_st", 8'h00, o_st);
        chk("reset_codes", 8'h00, {2'h0, o_cmp, o_fop});
        t_cmp();
        t_ops();
        t_single();
        t_cull();
        wrap_up();
    end
endmodule
`default_nettype wire

// File: core/bsto_pkg.sv
// Package with field layouts, encodings and widths for the back-face stencil stage.
`default_nettype none
package bsto_pkg;
    // Width of the stencil value held per pixel.
    localparam int STENCIL_W = 8;

    // Field positions inside the pipeline state word.
    localparam int STATE_W        = 32;
    localparam int CMP_FIELD_HI   = 14;
    localparam int CMP_FIELD_LO   = 12;
    localparam int FAIL_FIELD_HI  = 11;
    localparam int FAIL_FIELD_LO  = 9;
    localparam int CODE_W         = 3;

    // Comparison function encodings.
    typedef enum logic [2:0] {
        cmp_always_pass      = 3'h0,
        cmp_never_pass       = 3'h1,
        cmp_less_than        = 3'h2,
        cmp_equal_to         = 3'h3,
        cmp_less_or_equal    = 3'h4,
        cmp_greater_than     = 3'h5,
        cmp_not_equal        = 3'h6,
        cmp_greater_or_equal = 3'h7
    } bsto_compare_function_code_t;

    // Stencil buffer update encodings.
    typedef enum logic [2:0] {
        upd_keep           = 3'h0,
        upd_clear          = 3'h1,
        upd_load_reference = 3'h2,
        upd_inc_clamp      = 3'h3,
        upd_dec_clamp      = 3'h4,
        upd_inc_wrap       = 3'h5,
        upd_dec_wrap       = 3'h6,
        upd_bitwise_not    = 3'h7
    } bsto_stencil_update_code_t;

    // Reset value of the registered code outputs.
    localparam logic [2:0] RST_CODE = 3'h0;
endpackage
`default_nettype wire

// File: core/bsto_stage.sv
// Back-face stencil test and fail-update stage, one pixel per cycle.
`timescale 1ns/1ps
`default_nettype none
module bsto_stage
    import bsto_pkg::*;
#(
    parameter int W = STENCIL_W
) (
    // Clock and reset.
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Pipeline state.
    input  wire logic [STATE_W-1:0] state_word,
    input  wire logic               double_sided_en,
    input  wire logic [CODE_W-1:0]  front_cmp_code,
    input  wire logic [CODE_W-1:0]  front_fail_code,
    input  wire logic               front_ccw,
    input  wire logic               cull_back_en,
    // Pixel input.
    input  wire logic               pix_valid,
    input  wire logic               prim_ccw,
    input  wire logic [W-1:0]       stencil_ref,
    input  wire logic [W-1:0]       stencil_cur,
    // Pixel result.
    output logic                    res_valid_ff,
    output logic                    res_back_ff,
    output logic                    res_culled_ff,
    output logic                    res_pass_ff,
    output logic [CODE_W-1:0]       res_cmp_ff,
    output logic [CODE_W-1:0]       res_fail_op_ff,
    output logic [W-1:0]            res_stencil_ff
);
    // Comparison of reference against buffer value, reused per face.
    function automatic logic cmp_eval(input logic [CODE_W-1:0] code,
                                      input logic [W-1:0] r,
                                      input logic [W-1:0] s);
        case (bsto_compare_function_code_t'(code))
            cmp_always_pass:      cmp_eval = 1'b1;
            cmp_never_pass:       cmp_eval = 1'b0;
            cmp_less_than:        cmp_eval = r <  s;
            cmp_equal_to:         cmp_eval = r == s;
            cmp_less_or_equal:    cmp_eval = r <= s;
            cmp_greater_than:     cmp_eval = r >  s;
            cmp_not_equal:        cmp_eval = r != s;
            cmp_greater_or_equal: cmp_eval = r >= s;
            default:              cmp_eval = 1'b0;
        endcase
    endfunction

    logic [CODE_W-1:0] back_cmp_code;
    logic [CODE_W-1:0] back_fail_code;
    logic              is_back;
    logic              use_back;
    logic [CODE_W-1:0] sel_cmp;
    logic [CODE_W-1:0] sel_fail;
    logic              pass;
    logic [W-1:0]      fail_val;
    logic              nxt_valid;
    logic              nxt_back;
    logic              nxt_culled;
    logic              nxt_pass;
    logic [CODE_W-1:0] nxt_cmp;
    logic [CODE_W-1:0] nxt_fail_op;
    logic [W-1:0]      nxt_stencil;

    // Field extraction from the state word.
    assign back_cmp_code  = state_word[CMP_FIELD_HI:CMP_FIELD_LO];
    assign back_fail_code = state_word[FAIL_FIELD_HI:FAIL_FIELD_LO];

    // Face selection; the back-face fields only win when double-sided is on,
    // so a disabled setting gives back faces the front compare and fail codes.
    always_comb begin
        is_back  = prim_ccw != front_ccw;
        use_back = is_back && double_sided_en;
        sel_cmp  = use_back ? back_cmp_code : front_cmp_code;
        sel_fail = use_back ? back_fail_code : front_fail_code;
        pass     = cmp_eval(sel_cmp, stencil_ref, stencil_cur);
    end

    // Update applied only when the test fails.
    bsto_update #(.W(W)) u_fail_upd (
        .op      (sel_fail),
        .cur_val (stencil_cur),
        .ref_val (stencil_ref),
        .new_val (fail_val)
    );

    // Next result; culling looks only at pixel valid, facing and cull enable.
    always_comb begin
        nxt_valid   = pix_valid;
        nxt_back    = is_back;
        nxt_culled  = pix_valid && is_back && cull_back_en;
        nxt_pass    = pass;
        nxt_cmp     = sel_cmp;
        nxt_fail_op = sel_fail;
        nxt_stencil = pass ? stencil_cur : fail_val;
        if (!rst_n) begin
            nxt_valid   = 1'b0;
            nxt_back    = 1'b0;
            nxt_culled  = 1'b0;
            nxt_pass    = 1'b0;
            nxt_cmp     = RST_CODE;
            nxt_fail_op = RST_CODE;
            nxt_stencil = '0;
        end
    end

    // Result registers; reset is folded into the next-value logic above.
    always_ff @(posedge clk) begin
        res_valid_ff   <= nxt_valid;
        res_back_ff    <= nxt_back;
        res_culled_ff  <= nxt_culled;
        res_pass_ff    <= nxt_pass;
        res_cmp_ff     <= nxt_cmp;
        res_fail_op_ff <= nxt_fail_op;
        res_stencil_ff <= nxt_stencil;
    end

    // A back-facing pixel while double-sided stencil is switched on.
    sequence s_back_sel;
        prim_ccw != front_ccw && double_sided_en;
    endsequence

    // Helper: face-routed codes and expected values, seen one cycle later.
    property p_back_cmp;
        @(posedge clk) disable iff (!rst_n)
        s_back_sel |=> res_cmp_ff == $past(back_cmp_code);
    endproperty
    a_back_cmp: assert property (p_back_cmp)
        else $error("Back face did not use its compare field.");

    property p_back_fail;
        @(posedge clk) disable iff (!rst_n)
        s_back_sel |=> res_fail_op_ff == $past(back_fail_code);
    endproperty
    a_back_fail: assert property (p_back_fail)
        else $error("Back face did not use its fail-op field.");

    property p_cull_indep;
        @(posedge clk) disable iff (!rst_n)
        pix_valid |=> res_culled_ff
            == ($past(is_back) && $past(cull_back_en));
    endproperty
    a_cull_indep: assert property (p_cull_indep)
        else $error("Cull decision depended on more than facing.");

    property p_single_sided;
        @(posedge clk) disable iff (!rst_n)
        !double_sided_en |=> res_cmp_ff == $past(front_cmp_code)
                           && res_fail_op_ff == $past(front_fail_code);
    endproperty
    a_single_sided: assert property (p_single_sided)
        else $error("Back-face state used with double-sided off.");

    property p_facing;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> res_back_ff == ($past(prim_ccw) ^ $past(front_ccw));
    endproperty
    a_facing: assert property (p_facing)
        else $error("Facing classification wrong.");

    property p_pass_keeps;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> !res_pass_ff || res_stencil_ff == $past(stencil_cur);
    endproperty
    a_pass_keeps: assert property (p_pass_keeps)
        else $error("Stencil changed on a passing test.");

    property p_inc_clamp;
        @(posedge clk) disable iff (!rst_n)
        (sel_fail == upd_inc_clamp && !pass && stencil_cur == '1)
            |=> res_stencil_ff == '1;
    endproperty
    a_inc_clamp: assert property (p_inc_clamp)
        else $error("Saturating increment did not clamp.");

    property p_inc_wrap;
        @(posedge clk) disable iff (!rst_n)
        (sel_fail == upd_inc_wrap && !pass && stencil_cur == '1)
            |=> res_stencil_ff == '0;
    endproperty
    a_inc_wrap: assert property (p_inc_wrap)
        else $error("Wrapping increment did not roll over.");

    // Decrements at zero: the clamp holds, the wrap goes to all ones.
    property p_dec_clamp;
        @(posedge clk) disable iff (!rst_n)
        (sel_fail == upd_dec_clamp && !pass && stencil_cur == '0)
            |=> res_stencil_ff == '0;
    endproperty
    a_dec_clamp: assert property (p_dec_clamp)
        else $error("Saturating decrement did not clamp.");

    property p_dec_wrap;
        @(posedge clk) disable iff (!rst_n)
        (sel_fail == upd_dec_wrap && !pass && stencil_cur == '0)
            |=> res_stencil_ff == '1;
    endproperty
    a_dec_wrap: assert property (p_dec_wrap)
        else $error("Wrapping decrement did not roll over.");

    // A failing test with the clear code must leave a zero stencil.
    property p_fail_clear;
        @(posedge clk) disable iff (!rst_n)
        (sel_fail == upd_clear && !pass) |=> res_stencil_ff == '0;
    endproperty
    a_fail_clear: assert property (p_fail_clear)
        else $error("Clear code on a failing test left a value.");

    // The two fixed compare codes ignore the operands entirely.
    property p_never_fails;
        @(posedge clk) disable iff (!rst_n)
        sel_cmp == cmp_never_pass |=> !res_pass_ff;
    endproperty
    a_never_fails: assert property (p_never_fails)
        else $error("Never-pass compare let a pixel pass.");

    property p_always_passes;
        @(posedge clk) disable iff (!rst_n)
        sel_cmp == cmp_always_pass |=> res_pass_ff;
    endproperty
    a_always_passes: assert property (p_always_passes)
        else $error("Always-pass compare failed a pixel.");
endmodule
`default_nettype wire

// File: core/bsto_update.sv
// Stencil value update unit for one selected update operation.
`timescale 1ns/1ps
`default_nettype none
module bsto_update
    import bsto_pkg::*;
#(
    parameter int W = STENCIL_W
) (
    // Operation select.
    input  wire logic [CODE_W-1:0] op,
    // Operands.
    input  wire logic [W-1:0]      cur_val,
    input  wire logic [W-1:0]      ref_val,
    // Result.
    output logic      [W-1:0]      new_val
);
    localparam logic [W-1:0] ALL_ONES = {W{1'b1}};
    localparam logic [W-1:0] ZERO     = '0;
    localparam logic [W-1:0] ONE      = {{(W-1){1'b0}}, 1'b1};

    // Saturating codes clamp at the ends, wrapping codes roll over.
    always_comb begin
        case (bsto_stencil_update_code_t'(op))
            upd_keep:           new_val = cur_val;
            upd_clear:          new_val = ZERO;
            upd_load_reference: new_val = ref_val;
            upd_inc_clamp:      new_val = (cur_val == ALL_ONES) ? ALL_ONES
                                          : cur_val + ONE;
            upd_dec_clamp:      new_val = (cur_val == ZERO) ? ZERO
                                          : cur_val - ONE;
            upd_inc_wrap:       new_val = cur_val + ONE;
            upd_dec_wrap:       new_val = cur_val - ONE;
            upd_bitwise_not:    new_val = ~cur_val;
            default:            new_val = cur_val;
        endcase
    end
endmodule
`default_nettype wire
